// ==== rtl/clock_gate_pkg.sv ====
package clock_gate_pkg;

	// System clock rate and strap capture window
	localparam int CLK_MHZ        = 100;
	localparam int STRAP_TIME_US  = 2000;
	localparam int STRAP_CYCLES   = STRAP_TIME_US * CLK_MHZ;
	localparam int STRAP_CNT_W    = 18;

	// Model clock half periods in system clock cycles, and the speed codes that pick the bus divider
	localparam logic [3:0] REF_HALF    = 4'h3;
	localparam logic [3:0] USB_HALF    = 4'h1;
	localparam logic [3:0] DIV_BY_2    = 4'h2;
	localparam logic [3:0] DIV_BY_3    = 4'h3;
	localparam logic [3:0] DIV_BY_4    = 4'h4;
	localparam logic [1:0] TOP_DIV4    = 2'h3;
	localparam logic [3:0] CODE_DIV2_LO = 4'h1;
	localparam logic [3:0] CODE_DIV2_HI = 4'h3;

	// Register map, byte addresses
	localparam logic [7:0] CTRL_ADDR   = 8'h00;
	localparam logic [7:0] STATUS_ADDR = 8'h04;
	localparam logic [3:0] CTRL_RESET  = 4'h0;

	// Field positions
	localparam int CTRL_OVR_BIT    = 0;
	localparam int CTRL_CODE_LSB   = 4;
	localparam int ST_CODE_LSB     = 0;
	localparam int ST_MODE_BIT     = 4;
	localparam int ST_DONE_BIT     = 5;
	localparam int ST_HALT_BIT     = 6;
	localparam int ST_BHALT_BIT    = 7;
	localparam int ST_DIV_LSB      = 8;

	typedef struct packed {
		logic       mode;
		logic [3:0] speed_select;
	} strap_t;

	typedef struct packed {
		logic       override;
		logic [3:0] speed_select;
	} sw_cfg_t;

	typedef struct packed {
		logic i;
		logic o;
		logic oe;
	} pin_t;

endpackage : clock_gate_pkg

// ==== rtl/clock_output_gating_select.sv ====
// Notes on behaviour
// - Mode strap picks pin 3 function
// - Speed code sets bus divider 4/2/3
// - Software may override strapped speed code
// - Gated processor clocks stop on halt
// - Free processor clock always toggles
// - Bus gated clocks held low on pin 3 bus halt
// - Free bus clock always toggles
// - Stop after full cycle, 2-3 clocks
// - Restart with full cycle, no runt
// - Gated apic clock disabled on halt
// - Free apic clock never stopped
// - Pin 9 latches top bit, then clock
// - Pin 29 latches bit 1, then usb
// - Bus halt sampled on free rise
// - Shared pins undriven during capture window
// - Pin 30 latches bit 0, then 24MHz
module clock_output_gating_select #(
	parameter int STRAP_CYCLES = clock_gate_pkg::STRAP_CYCLES
) (
	input  wire logic        clock,
	input  wire logic        reset,
	// Wishbone classic slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic [31:0]      dat_o,
	output logic             ack_o,
	// Halt input
	input  wire logic        clock_halt_n,
	// Dual purpose pins
	input  wire logic        pin2_i,
	output logic             pin2_o,
	output logic             pin2_oe,
	input  wire logic        pin3_i,
	output logic             pin3_o,
	output logic             pin3_oe,
	input  wire logic        pin8_i,
	output logic             pin8_o,
	output logic             pin8_oe,
	input  wire logic        pin9_i,
	output logic             pin9_o,
	output logic             pin9_oe,
	input  wire logic        pin29_i,
	output logic             pin29_o,
	output logic             pin29_oe,
	input  wire logic        pin30_i,
	output logic             pin30_o,
	output logic             pin30_oe,
	// Clock outputs
	output logic             processor_clk_free,
	output logic [1:0]       processor_clk_gated,
	output logic [4:0]       bus_clk_gated,
	output logic             apic_clk_free,
	output logic             apic_clk_gated,
	output logic [3:0]       freq_code,
	output logic [3:0]       bus_divider
);

	function automatic logic [3:0] bus_div(input logic [3:0] code);
		if (code[3:2] == clock_gate_pkg::TOP_DIV4)
			bus_div = clock_gate_pkg::DIV_BY_4;
		else if (code >= clock_gate_pkg::CODE_DIV2_LO && code <= clock_gate_pkg::CODE_DIV2_HI)
			bus_div = clock_gate_pkg::DIV_BY_2;
		else
			bus_div = clock_gate_pkg::DIV_BY_3;
	endfunction : bus_div

	// Input synchronisers
	logic [4:0] strap_s1_r;
	logic [4:0] strap_s2_r;
	logic       halt_s1_r;
	logic       halt_s2_r;
	logic       bhalt_s1_r;
	logic       bhalt_s2_r;

	always_ff @(posedge clock) begin
		strap_s1_r <= {pin8_i, pin9_i, pin2_i, pin29_i, pin30_i};
		strap_s2_r <= strap_s1_r;
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			halt_s1_r <= 1'b1;
			halt_s2_r <= 1'b1;
		end else begin
			halt_s1_r <= clock_halt_n;
			halt_s2_r <= halt_s1_r;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			bhalt_s1_r <= 1'b1;
			bhalt_s2_r <= 1'b1;
		end else begin
			bhalt_s1_r <= pin3_i;
			bhalt_s2_r <= bhalt_s1_r;
		end
	end

	// Strap capture window
	logic [clock_gate_pkg::STRAP_CNT_W-1:0] strap_cnt_r;
	logic                                   strap_done_r;
	clock_gate_pkg::strap_t                 strap_r;

	always_ff @(posedge clock) begin
		if (reset) begin
			strap_cnt_r  <= '0;
			strap_done_r <= 1'b0;
		end else if (!strap_done_r) begin
			if (strap_cnt_r == clock_gate_pkg::STRAP_CNT_W'(STRAP_CYCLES - 1))
				strap_done_r <= 1'b1;
			strap_cnt_r <= strap_cnt_r + 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			strap_r <= '0;
		end else if (!strap_done_r) begin
			strap_r.mode         <= strap_s2_r[4];
			strap_r.speed_select <= strap_s2_r[3:0];
		end
	end

	// Register interface
	clock_gate_pkg::sw_cfg_t sw_cfg_r;
	logic                    ack_r;
	logic                    bus_req;
	logic [31:0]             rd_data;
	logic                    proc_en_r;
	logic                    bus_en_r;

	assign bus_req = cyc_i & stb_i & ~ack_r;
	assign ack_o   = ack_r;

	always_ff @(posedge clock) begin
		if (reset)
			ack_r <= 1'b0;
		else
			ack_r <= bus_req;
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			sw_cfg_r <= '0;
		end else if (cyc_i && stb_i && ack_r && we_i && sel_i[0] && adr_i == clock_gate_pkg::CTRL_ADDR) begin
			sw_cfg_r.override     <= dat_i[clock_gate_pkg::CTRL_OVR_BIT];
			sw_cfg_r.speed_select <= dat_i[clock_gate_pkg::CTRL_CODE_LSB +: 4];
		end
	end

	always_comb begin
		rd_data = '0;
		case (adr_i)
			clock_gate_pkg::CTRL_ADDR: begin
				rd_data[clock_gate_pkg::CTRL_OVR_BIT]       = sw_cfg_r.override;
				rd_data[clock_gate_pkg::CTRL_CODE_LSB +: 4] = sw_cfg_r.speed_select;
			end
			clock_gate_pkg::STATUS_ADDR: begin
				rd_data[clock_gate_pkg::ST_CODE_LSB +: 4] = strap_r.speed_select;
				rd_data[clock_gate_pkg::ST_MODE_BIT]      = strap_r.mode;
				rd_data[clock_gate_pkg::ST_DONE_BIT]      = strap_done_r;
				rd_data[clock_gate_pkg::ST_HALT_BIT]      = proc_en_r;
				rd_data[clock_gate_pkg::ST_BHALT_BIT]     = bus_en_r;
				rd_data[clock_gate_pkg::ST_DIV_LSB +: 4]  = bus_divider;
			end
			default: rd_data = '0;
		endcase
	end

	always_ff @(posedge clock) begin
		if (reset)
			dat_o <= '0;
		else if (bus_req && !we_i)
			dat_o <= rd_data;
	end

	// Frequency selection
	logic [3:0] code_sel;
	assign code_sel = sw_cfg_r.override ? sw_cfg_r.speed_select : strap_r.speed_select;

	always_ff @(posedge clock) begin
		if (reset)
			freq_code <= '0;
		else
			freq_code <= code_sel;
	end

	// Processor clock: toggles every system clock
	logic proc_r;
	logic proc_rise;
	logic halt_p1_r;

	assign proc_rise = ~proc_r;

	always_ff @(posedge clock) begin
		if (reset)
			proc_r <= 1'b0;
		else
			proc_r <= ~proc_r;
	end

	// Enable changes only at a rising point, so every pulse is whole
	always_ff @(posedge clock) begin
		if (reset) begin
			halt_p1_r <= 1'b1;
			proc_en_r <= 1'b1;
		end else if (proc_rise) begin
			halt_p1_r <= halt_s2_r;
			proc_en_r <= halt_p1_r;
		end
	end

	assign processor_clk_free  = proc_r;
	assign processor_clk_gated = {2{proc_r & proc_en_r}};

	// Bus clock counted from system clock, period twice bus_divider
	logic [3:0] bus_cnt_r;
	logic       bus_free;
	logic       bus_rise;
	logic       bhalt_n;
	logic       bhalt_smp_r;

	assign bus_free = (bus_cnt_r < bus_divider);
	assign bus_rise = (bus_cnt_r == {bus_divider[2:0], 1'b0} - 4'h1);

	always_ff @(posedge clock) begin
		if (reset) begin
			bus_cnt_r   <= '0;
			bus_divider <= clock_gate_pkg::DIV_BY_3;
		end else if (bus_rise) begin
			bus_cnt_r   <= '0;
			bus_divider <= bus_div(code_sel);
		end else begin
			bus_cnt_r <= bus_cnt_r + 4'h1;
		end
	end

	assign bhalt_n = strap_done_r && !strap_r.mode ? bhalt_s2_r : 1'b1;

	always_ff @(posedge clock) begin
		if (reset) begin
			bhalt_smp_r <= 1'b1;
			bus_en_r    <= 1'b1;
		end else if (bus_rise) begin
			bhalt_smp_r <= bhalt_n;
			bus_en_r    <= bhalt_smp_r;
		end
	end

	logic bus_gated;
	assign bus_gated     = bus_free & bus_en_r;
	assign bus_clk_gated = {5{bus_gated}};

	// Reference clock and its apic copies
	logic [3:0] ref_cnt_r;
	logic       ref_r;
	logic       apic_en_r;

	always_ff @(posedge clock) begin
		if (reset) begin
			ref_cnt_r <= '0;
			ref_r     <= 1'b0;
		end else if (ref_cnt_r == clock_gate_pkg::REF_HALF - 4'h1) begin
			ref_cnt_r <= '0;
			ref_r     <= ~ref_r;
		end else begin
			ref_cnt_r <= ref_cnt_r + 4'h1;
		end
	end

	always_ff @(posedge clock) begin
		if (reset)
			apic_en_r <= 1'b1;
		else if (!ref_r && ref_cnt_r == clock_gate_pkg::REF_HALF - 4'h1)
			apic_en_r <= halt_s2_r;
	end

	assign apic_clk_free  = ref_r;
	assign apic_clk_gated = ref_r & apic_en_r;

	// Usb clock and its half
	logic [3:0] usb_cnt_r;
	logic       usb_r;
	logic       half_r;

	always_ff @(posedge clock) begin
		if (reset) begin
			usb_cnt_r <= '0;
			usb_r     <= 1'b0;
			half_r    <= 1'b0;
		end else if (usb_cnt_r == clock_gate_pkg::USB_HALF - 4'h1) begin
			usb_cnt_r <= '0;
			usb_r     <= ~usb_r;
			if (usb_r)
				half_r <= ~half_r;
		end else begin
			usb_cnt_r <= usb_cnt_r + 4'h1;
		end
	end

	// Pin drivers: three-stated during capture window
	assign pin2_oe  = strap_done_r;
	assign pin2_o   = strap_done_r & ref_r;
	assign pin3_oe  = strap_done_r & strap_r.mode;
	assign pin3_o   = pin3_oe & ref_r;
	assign pin8_oe  = strap_done_r;
	assign pin8_o   = strap_done_r & bus_free;
	assign pin9_oe  = strap_done_r;
	assign pin9_o   = strap_done_r & bus_gated;
	assign pin29_oe = strap_done_r;
	assign pin29_o  = strap_done_r & usb_r;
	assign pin30_oe = strap_done_r;
	assign pin30_o  = strap_done_r & half_r;

	// Assertions
	default clocking @(posedge clock); endclocking
	default disable iff (reset);

	sequence halt_low_seq;
		!halt_s2_r ##1 !halt_s2_r;
	endsequence

	a_pins_undriven: assert property (!strap_done_r |-> !pin2_oe && !pin3_oe && !pin8_oe && !pin9_oe && !pin29_oe && !pin30_oe)
		else $error("shared pin driven during capture");
	a_straps_frozen: assert property (strap_done_r |=> $stable(strap_r) && strap_done_r)
		else $error("strap value changed after capture");
	a_pin3_mode: assert property (strap_done_r |-> pin3_oe == strap_r.mode)
		else $error("pin 3 direction wrong");
	a_proc_free_runs: assert property (!$past(reset) |-> processor_clk_free != $past(processor_clk_free))
		else $error("free processor clock stalled");
	a_halt_stops: assert property (halt_low_seq ##0 !halt_s2_r [*4] |=> !processor_clk_gated[0])
		else $error("gated processor clock not stopped");
	a_no_runt: assert property ($rose(proc_en_r) |-> proc_r && !$past(proc_r))
		else $error("processor enable changed while high");
	a_restart_latency: assert property ($rose(halt_s2_r) |-> ##[1:4] proc_en_r)
		else $error("processor restart too slow");
	a_bus_held_low: assert property (!bus_en_r |-> !bus_clk_gated[0] && !pin9_o)
		else $error("gated bus clock not low");
	a_bus_sample: assert property (bus_rise |=> bhalt_smp_r == $past(bhalt_n))
		else $error("bus halt not sampled on free rise");
	a_apic_gate: assert property (!apic_en_r |-> !apic_clk_gated && apic_clk_free == ref_r)
		else $error("apic clock gating wrong");
	a_divider_code: assert property (bus_rise |=> bus_divider == bus_div($past(code_sel)))
		else $error("bus divider does not match code");

endmodule : clock_output_gating_select

// ==== testbench/strap_partner.sv ====
module strap_partner (
	input  wire logic [4:0] strap,
	input  wire logic       bus_halt_n,
	input  wire logic [5:0] oe,
	input  wire logic [5:0] o,
	output logic      [5:0] pin_i
);
	timeunit 1ns;
	timeprecision 1ps;
	// Bit order: pin8, pin9, pin2, pin29, pin30 straps, then pin3 halt
	logic [5:0] idle;
	assign idle = {strap, bus_halt_n};
	// Resistor or halt source shows whenever the device releases a pin
	always_comb begin
		for (int k = 0; k < 6; k++) begin
			pin_i[k] = oe[k] ? o[k] : idle[k];
		end
	end
endmodule : strap_partner

// ==== testbench/test_clock_output_gating_select.sv ====
module test_clock_output_gating_select;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clock, reset, cyc_i, stb_i, we_i, ack_o, clock_halt_n, bus_halt_n;
	logic [7:0]  adr_i;
	logic [3:0]  sel_i, freq_code, bus_divider;
	logic [31:0] dat_i, dat_o, rd;
	logic [5:0]  pin_i, pin_o, pin_oe;
	logic        processor_clk_free, apic_clk_free, apic_clk_gated;
	logic [1:0]  processor_clk_gated;
	logic [4:0]  bus_clk_gated, strap;
	logic [10:0] hi, lo, sig;
	integer      seed, n_errors, compares;

	clock_output_gating_select #(.STRAP_CYCLES(20)) DUT (.clock(clock), .reset(reset),
		.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
		.dat_o(dat_o), .ack_o(ack_o), .clock_halt_n(clock_halt_n),
		.pin2_i(pin_i[3]), .pin2_o(pin_o[3]), .pin2_oe(pin_oe[3]),
		.pin3_i(pin_i[0]), .pin3_o(pin_o[0]), .pin3_oe(pin_oe[0]),
		.pin8_i(pin_i[5]), .pin8_o(pin_o[5]), .pin8_oe(pin_oe[5]),
		.pin9_i(pin_i[4]), .pin9_o(pin_o[4]), .pin9_oe(pin_oe[4]),
		.pin29_i(pin_i[2]), .pin29_o(pin_o[2]), .pin29_oe(pin_oe[2]),
		.pin30_i(pin_i[1]), .pin30_o(pin_o[1]), .pin30_oe(pin_oe[1]),
		.processor_clk_free(processor_clk_free), .processor_clk_gated(processor_clk_gated),
		.bus_clk_gated(bus_clk_gated), .apic_clk_free(apic_clk_free),
		.apic_clk_gated(apic_clk_gated), .freq_code(freq_code), .bus_divider(bus_divider));

	strap_partner partner (.strap(strap), .bus_halt_n(bus_halt_n), .oe(pin_oe), .o(pin_o), .pin_i(pin_i));

	assign sig = {pin_o[3:0], processor_clk_free, |processor_clk_gated, apic_clk_free, apic_clk_gated,
		pin_o[5], |bus_clk_gated, pin_o[4]};

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	task automatic close_out;
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : close_out

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : check

	function automatic logic [3:0] div_of(input logic [3:0] c);
		if (c[3:2] == 2'b11) return 4'h4;
		if (c >= 4'h1 && c <= 4'h3) return 4'h2;
		return 4'h3;
	endfunction : div_of

	// Classic single cycle; waits for ack, then releases for one cycle
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int n;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= we;
		adr_i <= a;
		dat_i <= d;
		sel_i <= 4'h1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		rd = dat_o;
		check(n < 20, 1, "no ack");
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
		@(posedge clock);
	endtask : wb

	// Records which watched outputs were seen high and low
	task automatic span(input int n);
		hi = '0;
		lo = '0;
		repeat (n) begin
			@(posedge clock);
			hi |= sig;
			lo |= ~sig;
		end
	endtask : span

	task automatic run_mode(input logic m);
		logic [3:0] code;
		int n;
		code = 4'($random(seed));
		strap <= {m, code};
		reset <= 1'b1;
		repeat (4) @(posedge clock);
		reset <= 1'b0;
		repeat (20) begin
			@(posedge clock);
			check(pin_oe, 0, "pin driven in capture");
		end
		n = 0;
		while (pin_oe[4] !== 1'b1 && n < 200) begin
			@(posedge clock);
			n++;
		end
		repeat (10) @(posedge clock);
		check(pin_oe, {5'h1f, m}, "pin roles");
		check(freq_code, code, "strap code");
		check(bus_divider, div_of(code), "divider");
		wb(1'b0, 8'h04, 0);
		check(rd[11:0], {div_of(code), 3'b111, m, code}, "status");
		strap <= ~strap;
		repeat (5) @(posedge clock);
		check(freq_code, code, "strap frozen");
		for (int c = 0; c < 16; c++) begin
			wb(1'b1, 8'h00, {24'h0, 4'(c), 4'h1});
			repeat (12) @(posedge clock);
			check(freq_code, c, "sw code");
			check(bus_divider, div_of(4'(c)), "sw divider");
		end
		wb(1'b1, 8'h00, 0);
		repeat (12) @(posedge clock);
		check(freq_code, code, "override off");
		wb(1'b0, 8'h08, 0);
		check(rd, 0, "unmapped read");
		clock_halt_n <= 1'b0;
		repeat (10) @(posedge clock);
		span(16);
		check({hi[6], lo[6], hi[5], hi[4], lo[4], hi[3]}, 6'b110110, "halted");
		check(hi[2:0] & lo[2:0], 3'b111, "bus runs");
		check(hi[10:7] & lo[10:7], {3'b111, m}, "shared outputs");
		clock_halt_n <= 1'b1;
		repeat (10) @(posedge clock);
		span(16);
		check({hi[5], lo[5], hi[3], lo[3]}, 4'hf, "restart");
		bus_halt_n <= 1'b0;
		repeat (20) @(posedge clock);
		span(16);
		check(hi[1:0], m ? 2'b11 : 2'b00, "bus halt");
		check(hi[2] & lo[2], 1, "bus free");
		bus_halt_n <= 1'b1;
		repeat (20) @(posedge clock);
		span(16);
		check(hi[1:0] & lo[1:0], 2'b11, "bus restart");
		$display("test mode %0d done", m);
	endtask : run_mode

	initial begin
		seed = 32'h0000_8403;
		n_errors = 0;
		compares = 0;
		reset = 1'b1;
		cyc_i = 1'b0;
		stb_i = 1'b0;
		we_i = 1'b0;
		adr_i = 8'h00;
		sel_i = 4'h0;
		dat_i = 32'h0000_0000;
		clock_halt_n = 1'b1;
		bus_halt_n = 1'b1;
		strap = 5'h00;
		@(posedge clock);
		run_mode(1'b1);
		run_mode(1'b0);
		close_out();
	end

	initial begin
		#100000;
		n_errors++;
		close_out();
	end
endmodule : test_clock_output_gating_select
